// File: bench/qpc_far_model.sv
// Purpose: Far-side pins: encoder A/B/index, PWM gate, external clock, trigger
// Assumes: Pins change just after a sys_clk rising edge
// Notes:   External clock stands still between bursts
`timescale 1ns/10ps
module qpc_far_model
(
	input  wire logic sys_clk,
	output logic      firstInput,
	output logic      secondInput,
	output logic      indexInput
);
	initial
	begin
		firstInput = 1'b0;
		secondInput = 1'b0;
		indexInput = 1'b0;
	end
	task automatic pins(input logic a, input logic b, input logic c, input int hold);
		@(posedge sys_clk);
		firstInput <= a;
		secondInput <= b;
		indexInput <= c;
		repeat (hold) @(posedge sys_clk);
	endtask
	// One quadrature cycle from state 00; up means A leads B
	task automatic cycle(input logic up, input logic c, input int hold);
		pins(up, !up, c, hold);
		pins(1'b1, 1'b1, c, hold);
		pins(!up, up, c, hold);
		pins(1'b0, 1'b0, c, hold);
	endtask
	task automatic clocks(input int n);
		repeat (n)
		begin
			pins(firstInput, 1'b1, indexInput, 4);
			pins(firstInput, 1'b0, indexInput, 4);
		end
	endtask
	// Single trigger per run, never while running
	task automatic trig();
		pins(firstInput, secondInput, 1'b1, 8);
		pins(firstInput, secondInput, 1'b0, 8);
	endtask
endmodule

// File: bench/tb_quadrature_and_pwm_counter.sv
// Purpose: Self-checking bench for the quadrature and PWM counter channel
// Assumes: Zero-wait-state slave, one master, far pins from the model
// Notes:   Timeout cuts the run after 20000 cycles
`timescale 1ns/10ps
module tb_quadrature_and_pwm_counter;
	import qpc_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        ce = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        counterOut;
	logic        intReq;
	wire logic   firstInput;
	wire logic   secondInput;
	wire logic   indexInput;
	int          mismatches = 0;
	int          samplesChecked = 0;
	int          cycles = 0;
	int          edges = 0;
	int          irqs = 0;
	int          toggles[$];
	logic        prevB = 1'b0;
	logic        prevOut = 1'b1;
	logic [31:0] rd;

	always #10 sys_clk = ~sys_clk;

	qpc_counter #(.CNT_W(32)) u_dut
	(
		.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.firstInput(firstInput), .secondInput(secondInput), .indexInput(indexInput),
		.counterOut(counterOut), .intReq(intReq)
	);
	qpc_far_model u_far
	(
		.sys_clk(sys_clk), .firstInput(firstInput), .secondInput(secondInput),
		.indexInput(indexInput)
	);

	// ------------------------------------------------------------
	// Monitor and timeout
	// ------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		cycles++;
		if (intReq === 1'b1)
			irqs++;
		if (secondInput === 1'b1 && prevB === 1'b0)
			edges++;
		if (counterOut !== prevOut)
		begin
			toggles.push_back(edges);
			edges = 0;
		end
		prevB = secondInput;
		prevOut = counterOut;
		if (cycles == 20000)
		begin
			mismatches++;
			$display("[FAIL] timeout expected finish seen hang");
			summarize();
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", samplesChecked, mismatches);
		if (mismatches == 0 && samplesChecked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samplesChecked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'b10;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(what, exp, rd);
	endtask
	task automatic waitToggle(output int n);
		logic o;
		o = counterOut;
		n = 0;
		while (counterOut === o && n < 3000)
		begin
			@(posedge sys_clk);
			n++;
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		check("outRest", 32'h1, {31'h0, counterOut});
		check("irqIdle", 32'h0, {31'h0, intReq});
		check("okay", 32'h0, {31'h0, hresp});
		rdchk("ctrlRst", OFS_CONTROL, 32'h0);
		wr(OFS_CONST_A, 32'h0000_1234);
		rdchk("constA", OFS_CONST_A, 32'h0000_1234);
		wr(OFS_CONST_A, 32'h0);
		rdchk("unmapped", 8'h14, 32'h0);
		rdchk("trigRead", OFS_TRIGGER, 32'h0);
		wr(OFS_CONTROL, 32'hFFFF_FFF9);
		rdchk("ctrlRsvd", OFS_CONTROL, 32'h0000_EFF9);
		wr(OFS_CONTROL, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_quad();
		wr(OFS_CONTROL, 32'h0000_0061);
		wr(OFS_TRIGGER, 32'h1);
		repeat (3) u_far.cycle(1'b1, 1'b0, 8);
		u_far.cycle(1'b0, 1'b0, 8);
		rdchk("countX2", OFS_READBACK, 32'h4);
		wr(OFS_CONTROL, 32'h0000_2061);
		u_far.cycle(1'b1, 1'b0, 50);
		rdchk("countDeb", OFS_READBACK, 32'h4);
		u_far.cycle(1'b1, 1'b0, 130);
		rdchk("countPass", OFS_READBACK, 32'h6);
		$display("test quad done");
	endtask
	task automatic t_index();
		logic [1:0] want[8] = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b00, 2'b00, 2'b00, 2'b00};
		wr(OFS_GLOBAL, 32'h1);
		irqs = 0;
		for (int c = 0; c < 8; c++)
		begin
			wr(OFS_CONTROL, 32'h0000_8C61 | (32'(c) << 7));
			for (int s = 0; s < 4; s++)
			begin
				u_far.pins(s[1], s[0], 1'b1, 8);
				check("indexOut", {31'h0, !(c >= 1 && c <= 4 && s == want[c])},
					{31'h0, counterOut});
			end
			u_far.pins(1'b0, 1'b0, 1'b0, 8);
		end
		check("indexIrq", 32'd4, 32'(irqs));
		wr(OFS_CONTROL, 32'h0000_0DE1);
		irqs = 0;
		u_far.pins(1'b1, 1'b1, 1'b1, 8);
		check("ieOff", 32'h0, 32'(irqs));
		u_far.pins(1'b0, 1'b0, 1'b0, 8);
		$display("test index done");
	endtask
	task automatic t_reload();
		wr(OFS_CONST_B, 32'h10);
		wr(OFS_CONTROL, 32'h0000_89E9);
		irqs = 0;
		u_far.cycle(1'b1, 1'b1, 8);
		rdchk("reload", OFS_READBACK, 32'h11);
		check("reloadIrq", 32'h1, 32'(irqs));
		wr(OFS_CONST_A, 32'h13);
		wr(OFS_CONTROL, 32'h0000_8469);
		u_far.pins(1'b0, 1'b0, 1'b0, 8);
		check("matchIdle", 32'h0, {31'h0, counterOut});
		irqs = 0;
		u_far.cycle(1'b1, 1'b0, 8);
		check("matchOn", 32'h1, {31'h0, counterOut});
		u_far.cycle(1'b1, 1'b0, 8);
		check("matchOff", 32'h0, {31'h0, counterOut});
		check("matchIrq", 32'h1, 32'(irqs));
		$display("test reload done");
	endtask
	task automatic t_ext();
		wr(OFS_CONTROL, 32'h0);
		wr(OFS_CONST_A, 32'h3);
		wr(OFS_CONST_B, 32'h2);
		wr(OFS_CONTROL, 32'h0000_9652);
		u_far.pins(1'b1, 1'b0, 1'b0, 8);
		u_far.trig();
		toggles.delete();
		irqs = 0;
		u_far.clocks(5);
		check("gated", 32'h0, 32'(toggles.size()));
		u_far.pins(1'b0, 1'b0, 1'b0, 8);
		edges = 0;
		u_far.clocks(8);
		u_far.pins(1'b0, 1'b0, 1'b0, 8);
		check("toggleCount", 32'h3, 32'(toggles.size()));
		if (toggles.size() >= 3)
		begin
			check("ticksA", 32'h3, 32'(toggles[0]));
			check("ticksB", 32'h2, 32'(toggles[1]));
			check("ticksA2", 32'h3, 32'(toggles[2]));
		end
		check("pwmIrq", 32'h3, 32'(irqs));
		$display("test ext done");
	endtask
	task automatic t_rates();
		int per2[5] = '{80, 40, 20, 10, 5};
		int n;
		int e2;
		wr(OFS_CONST_A, 32'h3);
		wr(OFS_CONST_B, 32'h2);
		for (int c = 0; c < 5; c++)
		begin
			wr(OFS_CONTROL, 32'h0);
			wr(OFS_CONTROL, 32'h0000_0002 | (32'(c) << 10));
			wr(OFS_TRIGGER, 32'h1);
			waitToggle(n);
			waitToggle(n);
			e2 = per2[c] * ((c == 4) ? 3 : 2);
			check("activeLen", 32'(e2),
				32'((2 * n - e2 <= 2 && e2 - 2 * n <= 2) ? e2 : 2 * n));
		end
		wr(OFS_CONTROL, 32'h0);
		repeat (4) @(posedge sys_clk);
		check("restHigh", 32'h1, {31'h0, counterOut});
		$display("test rates done");
	endtask

	task automatic t_wide();
		ce <= 1'b0;
		u_far.cycle(1'b1, 1'b0, 8);
		ce <= 1'b1;
		rdchk("frozen", OFS_READBACK, 32'h15);
		wr(OFS_CONST_B, 32'h0);
		for (int w = 0; w < 2; w++)
		begin
			wr(OFS_CONTROL, 32'h0000_09E1 | (32'(w) << 14));
			u_far.pins(1'b1, 1'b1, 1'b1, 8);
			u_far.pins(1'b1, 1'b0, 1'b0, 8);
			u_far.pins(1'b0, 1'b0, 1'b0, 8);
			rdchk("wrap", OFS_READBACK, (w == 1) ? 32'hFFFF_FFFF : 32'h0000_FFFF);
		end
		$display("test wide done");
	endtask
	task automatic t_ext2();
		wr(OFS_CONTROL, 32'h0);
		u_far.pins(1'b1, 1'b0, 1'b1, 8);
		wr(OFS_CONTROL, 32'h0000_95AA);
		u_far.pins(1'b1, 1'b0, 1'b0, 8);
		toggles.delete();
		edges = 0;
		u_far.clocks(5);
		u_far.pins(1'b0, 1'b0, 1'b0, 8);
		u_far.clocks(3);
		check("lowTrigToggles", 32'h2, 32'(toggles.size()));
		if (toggles.size() >= 2)
		begin
			check("ticksA3", 32'h3, 32'(toggles[0]));
			check("ticksB2", 32'h2, 32'(toggles[1]));
		end
		wr(OFS_CONTROL, 32'h0);
		$display("test ext2 done");
	endtask

	initial
	begin
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		t_regs();
		t_quad();
		t_index();
		t_reload();
		t_wide();
		t_ext();
		t_ext2();
		t_rates();
		summarize();
	end
endmodule

// File: rtl/qpc_counter.sv
// Purpose: One quadrature position / PWM counter channel with AHB-Lite registers
// Assumes: Inputs synchronous to sys_clk, single-word AHB transfers, ce high during access
// Notes:   Internal rates are clock enables from a phase accumulator on sys_clk
`timescale 1ns/10ps
module qpc_counter
#(
	parameter int CNT_W = 32
)
(
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	input  wire logic              ce,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic              hready,
	input  wire logic [31:0]       hwdata,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic              firstInput,
	input  wire logic              secondInput,
	input  wire logic              indexInput,
	output logic                   counterOut,
	output logic                   intReq
);
	import qpc_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [CNT_W-1:0] widthMask(input logic [CNT_W-1:0] v, input logic wide);
		widthMask = wide ? v : (v & CNT_W'(32'h0000_FFFF));
	endfunction

	function automatic logic phaseMatch(input logic [2:0] code, input logic a, input logic b);
		case (code)
			3'b001:  phaseMatch = !a && b;
			3'b010:  phaseMatch = a && !b;
			3'b011:  phaseMatch = a && b;
			3'b100:  phaseMatch = !a && !b;
			default: phaseMatch = 1'b0;
		endcase
	endfunction

	function automatic logic [12:0] rateInc(input logic [2:0] src);
		case (src)
			3'b000:  rateInc = RATE_1M25;
			3'b001:  rateInc = RATE_1M25 << 1;
			3'b010:  rateInc = RATE_1M25 << 2;
			3'b011:  rateInc = RATE_1M25 << 3;
			3'b100:  rateInc = RATE_1M25 << 4;
			default: rateInc = 13'h0000;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------
	logic [15:0]      control;
	logic [31:0]      constA;
	logic [31:0]      constB;
	logic             globalIe;
	logic             wrPend;
	logic [7:0]       wrAddr;
	logic [2:0]       sync1;
	logic [2:0]       sync2;
	logic [2:0]       filt;
	logic [2:0]       filtQ;
	logic [7:0]       debCnt [3];
	logic [12:0]      rateAcc;
	logic [CNT_W-1:0] count;
	logic             runQ;
	logic             runP;
	logic             pwmPhase;
	logic             idxCondQ;
	logic             matchQ;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire       addrPhase = hsel && htrans[1] && hready;
	wire       writeNow  = wrPend && hready;
	wire [7:0] rdAddr    = haddr[7:0];
	wire       swTrig    = writeNow && wrAddr == OFS_TRIGGER;
	wire       modeQuad  = control[2:0] == MODE_QUAD;
	wire       modePwm   = control[2:0] == MODE_PWM;
	wire       wide      = control[B_WIDE];
	wire [15:0] ctrlRead = modeQuad ? (control & ~(16'h0001 << B_RSVD)) : control;
	wire [31:0] countWord = 32'(count);
	wire [31:0] readMux =
		(rdAddr == OFS_CONTROL)  ? {16'h0000, ctrlRead} :
		(rdAddr == OFS_CONST_A)  ? constA :
		(rdAddr == OFS_CONST_B)  ? constB :
		(rdAddr == OFS_READBACK) ? countWord :
		(rdAddr == OFS_GLOBAL)   ? {31'h0000_0000, globalIe} : 32'h0000_0000;

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			wrPend    <= 1'b0;
			wrAddr    <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else if (ce)
		begin
			wrPend <= addrPhase && hwrite;
			if (addrPhase)
				wrAddr <= haddr[7:0];
			if (addrPhase && !hwrite)
				hrdata <= readMux;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			control  <= CONTROL_RST;
			constA   <= CONST_RST;
			constB   <= CONST_RST;
			globalIe <= 1'b0;
		end
		else if (ce && writeNow)
		begin
			if (wrAddr == OFS_CONTROL)
				control <= hwdata[15:0];
			if (wrAddr == OFS_CONST_A)
				constA <= hwdata;
			if (wrAddr == OFS_CONST_B)
				constB <= hwdata;
			if (wrAddr == OFS_GLOBAL)
				globalIe <= hwdata[0];
		end
	end

	// ------------------------------------------------------------
	// Input synchronise and debounce
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			filtQ <= 3'h0;
		end
		else if (ce)
		begin
			sync1 <= {indexInput, secondInput, firstInput};
			sync2 <= sync1;
			filtQ <= filt;
		end
	end

	wire [2:0] differs = sync2 ^ filt;

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			filt   <= 3'h0;
			debCnt <= '{default: 8'h00};
		end
		else if (ce)
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (!control[B_DEB] || (differs[i] && debCnt[i] == DEB_CYC))
					filt[i] <= sync2[i];
				debCnt[i] <= (control[B_DEB] && differs[i] && debCnt[i] != DEB_CYC) ?
					debCnt[i] + 8'h01 : 8'h00;
			end
		end
	end

	// ------------------------------------------------------------
	// Counting clock selection
	// ------------------------------------------------------------
	wire [2:0]  clkSrc   = control[B_CSRC_LO +: 3];
	wire [1:0]  bField   = control[B_CFLD_LO - 2 +: 2];
	wire [13:0] accSum   = {1'b0, rateAcc} + {1'b0, rateInc(clkSrc)};
	wire        intTick  = accSum >= {1'b0, RATE_MOD};
	wire [12:0] next_rateAcc = intTick ? 13'(accSum - {1'b0, RATE_MOD}) : accSum[12:0];
	wire        extEn    = clkSrc == CSRC_EXT && (bField == POL_LOW || bField == POL_HIGH);
	wire        bRise    = filt[1] && !filtQ[1];
	wire        tick     = extEn ? bRise : intTick;

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			rateAcc <= 13'h0000;
		else if (ce)
			rateAcc <= next_rateAcc;
	end

	// ------------------------------------------------------------
	// Quadrature decode
	// ------------------------------------------------------------
	wire       bEff   = control[B_BEN] && filt[1];
	wire       bEffQ  = control[B_BEN] && filtQ[1];
	wire       aEdge  = filt[0] != filtQ[0];
	wire       bEdge  = bEff != bEffQ;
	wire       upA    = filt[0] ^ bEff;
	wire       upB    = !(filt[0] ^ bEff);
	wire [1:0] enc    = control[B_AFLD_LO +: 2];
	wire [1:0] icf    = control[B_ICF_LO +: 2];
	wire       stepA  = aEdge && (enc == ENC_DOUBLE_RATE || enc == ENC_QUAD_RATE ||
	                              (enc == ENC_SINGLE && filt[0] == upA));
	wire       stepB  = !aEdge && bEdge && enc == ENC_QUAD_RATE;
	wire       stepUp = stepA ? upA : upB;
	wire       idxCond  = filt[2] && phaseMatch(control[B_PHASE_LO +: 3], filt[0], bEff);
	wire       idxEvent = idxCond && !idxCondQ;
	wire [CNT_W-1:0] limA = widthMask(CNT_W'(constA), wide);
	wire [CNT_W-1:0] limB = widthMask(CNT_W'(constB), wide);
	wire       matchNow = count == limA;
	wire       quadEvt  = runQ && ((icf == ICF_MATCH && matchNow && !matchQ) ||
	                               (icf[1] && idxEvent));

	// ------------------------------------------------------------
	// PWM sequencing
	// ------------------------------------------------------------
	wire [1:0] aField = control[B_AFLD_LO +: 2];
	wire [1:0] cField = control[B_CFLD_LO +: 2];
	wire       gateOk = (aField == POL_LOW)  ? !filt[0] :
	                    (aField == POL_HIGH) ?  filt[0] : 1'b1;
	wire       extTrig = (cField == POL_LOW  && !filt[2] && filtQ[2]) ||
	                     (cField == POL_HIGH &&  filt[2] && !filtQ[2]);
	wire       pwmTrig = modePwm && (swTrig || extTrig);
	wire [CNT_W-1:0] endCount = (clkSrc == CSRC_20M) ? '0 : CNT_W'(1);
	wire       pwmAdv    = runP && tick && gateOk;
	wire       pwmToggle = pwmAdv && count <= endCount;

	logic [CNT_W-1:0] next_count;
	always_comb
	begin
		next_count = count;
		if (pwmTrig)
			next_count = limA;
		else if (pwmToggle)
			next_count = pwmPhase ? limA : limB;
		else if (pwmAdv)
			next_count = count - CNT_W'(1);
		else if (runQ && idxEvent && icf == ICF_INDEX_RELOAD)
			next_count = limB;
		else if (runQ && (stepA || stepB))
			next_count = stepUp ? count + CNT_W'(1) : count - CNT_W'(1);
		next_count = widthMask(next_count, wide);
	end

	// ------------------------------------------------------------
	// Output and request
	// ------------------------------------------------------------
	wire quadDrive  = runQ && modeQuad && icf != 2'b00;
	wire quadActive = (icf == ICF_MATCH && matchNow) || (icf[1] && idxCond);
	wire pol        = control[B_POL];
	wire pwmDrive   = runP && modePwm;
	wire driven     = quadDrive || pwmDrive;
	wire active     = pwmDrive ? pwmPhase : quadActive;
	wire next_out   = driven ? (active ? pol : !pol) : 1'b1;
	wire next_int   = control[B_IE] && globalIe && (quadEvt || pwmToggle);

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			count      <= '0;
			runQ       <= 1'b0;
			runP       <= 1'b0;
			pwmPhase   <= 1'b0;
			idxCondQ   <= 1'b0;
			matchQ     <= 1'b0;
			counterOut <= 1'b1;
			intReq     <= 1'b0;
		end
		else if (ce)
		begin
			count      <= next_count;
			runQ       <= modeQuad && (runQ || swTrig);
			runP       <= modePwm && (runP || pwmTrig);
			pwmPhase   <= pwmTrig ? 1'b0 : (pwmToggle ? !pwmPhase : pwmPhase);
			idxCondQ   <= idxCond;
			matchQ     <= matchNow;
			counterOut <= next_out;
			intReq     <= next_int;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_idle_output_high: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && !modeQuad && !modePwm |=> counterOut)
		else $error("idle output not high");

	a_double_rate_up: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && runQ && enc == ENC_DOUBLE_RATE && aEdge && upA && !idxEvent && !pwmAdv
		|=> count == widthMask($past(count) + CNT_W'(1), wide))
		else $error("double rate count did not step up");

	a_index_reload: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && runQ && idxEvent && icf == ICF_INDEX_RELOAD |=> count == $past(limB))
		else $error("index reload missed");

	a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && addrPhase && !hwrite && rdAddr == OFS_CONTROL && modeQuad |=> !hrdata[B_RSVD])
		else $error("reserved bit read as one");

	a_narrow_width: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && !wide |=> count[CNT_W-1:16] == '0)
		else $error("narrow counter overflowed");

	a_irq_suppressed: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && !control[B_IE] |=> !intReq)
		else $error("request while disabled");

	a_pwm_irq_edge: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && pwmToggle && control[B_IE] && globalIe |=> intReq ##1 (!ce || !pwmAdv || !intReq))
		else $error("transition request missing");

	a_pwm_load_other: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && pwmToggle && !pwmTrig |=> count == ($past(pwmPhase) ? $past(limA) : $past(limB))
		&& pwmPhase != $past(pwmPhase))
		else $error("constant swap wrong");

	a_debounce_off: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && !control[B_DEB] |=> filt == $past(sync2))
		else $error("filter active while off");

	a_gate_holds: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && runP && !gateOk && !pwmTrig |=> $stable(count) && $stable(pwmPhase))
		else $error("gated counter moved");

	a_match_output: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && runQ && icf == ICF_MATCH && matchNow |=> counterOut == $past(pol))
		else $error("match output not active");

	a_index_output: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && runQ && modeQuad && icf[1] && idxCond |=> counterOut == $past(pol))
		else $error("index output not active");

	a_trigger_start: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && pwmTrig |=> runP && !pwmPhase && count == $past(limA))
		else $error("trigger did not start run");

	a_pwm_count_down: assert property (@(posedge sys_clk) disable iff (!rstn)
		ce && pwmAdv && !pwmToggle && !pwmTrig
		|=> count == widthMask($past(count) - CNT_W'(1), wide))
		else $error("constant not counted down");
endmodule

// File: rtl/qpc_pkg.sv
// Purpose: Shared constants for the quadrature and PWM counter channel
// Assumes: 50 MHz system clock, 32-bit AHB-Lite register access
// Notes:   Offsets are byte addresses of aligned words
package qpc_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL  = 8'h00;
	localparam logic [7:0] OFS_CONST_A  = 8'h04;
	localparam logic [7:0] OFS_CONST_B  = 8'h08;
	localparam logic [7:0] OFS_READBACK = 8'h0C;
	localparam logic [7:0] OFS_GLOBAL   = 8'h10;
	localparam logic [7:0] OFS_TRIGGER  = 8'h1C;
	localparam logic [15:0] CONTROL_RST = 16'h0000;
	localparam logic [31:0] CONST_RST   = 32'h0000_0000;
	// ------------------------------------------------------------
	// Control field positions
	// ------------------------------------------------------------
	localparam int B_MODE_LO  = 0;
	localparam int B_POL      = 3;
	localparam int B_AFLD_LO  = 4;
	localparam int B_BEN      = 6;
	localparam int B_CFLD_LO  = 8;
	localparam int B_PHASE_LO = 7;
	localparam int B_ICF_LO   = 10;
	localparam int B_CSRC_LO  = 10;
	localparam int B_RSVD     = 12;
	localparam int B_DEB      = 13;
	localparam int B_WIDE     = 14;
	localparam int B_IE       = 15;
	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		MODE_OFF  = 3'b000,
		MODE_QUAD = 3'b001,
		MODE_PWM  = 3'b010
	} qpc_mode_t;
	localparam logic [1:0] ENC_SINGLE          = 2'b01;
	localparam logic [1:0] ENC_DOUBLE_RATE     = 2'b10;
	localparam logic [1:0] ENC_QUAD_RATE       = 2'b11;
	localparam logic [1:0] ICF_MATCH           = 2'b01;
	localparam logic [1:0] ICF_INDEX_RELOAD    = 2'b10;
	localparam logic [1:0] POL_LOW             = 2'b01;
	localparam logic [1:0] POL_HIGH            = 2'b10;
	localparam logic [2:0] CSRC_20M            = 3'b100;
	localparam logic [2:0] CSRC_EXT            = 3'b101;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int SYS_PERIOD_NS = 20;
	localparam int DEB_TIME_NS   = 2400;
	localparam logic [7:0] DEB_CYC = 8'((DEB_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
	localparam logic [12:0] RATE_MOD = 13'd5000;
	localparam logic [12:0] RATE_1M25 = 13'd125;
endpackage
